//--- gsl_status_lamps.sv
// Three general-purpose pins multiplexed with active-low Ethernet status lamps.
`timescale 1ns/100ps
`include "gsl_regs.svh"
module gsl_status_lamps (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire gsl_pkg::gsl_phy_s phy,
  input wire logic [5:0] pin_mode,
  input wire logic [2:0] pin_out_val,
  input wire logic [2:0] status_lamp_pins_i,
  output gsl_pkg::gsl_pad_s status_lamp_pins,
  output logic [2:0] pin_in_val
);
  import gsl_pkg::*;
  // Length of one off or one on interval of the activity blink, counted on clk_sys.
  localparam logic [19:0] BLINK_CYC = 20'(`GSL_BLINK_CYC);

  logic [2:0] sync1_r;
  logic [2:0] sync2_r;
  logic [2:0] pin_in_val_r;
  gsl_blink_e state_r, state_nxt;
  logic [19:0] cnt_r, cnt_nxt;
  logic act_pend_r, act_pend_nxt;
  logic speed_lamp_n, link_activity_lamp_n, duplex_lamp_n;
  logic [2:0] lamp_n;
  gsl_pad_s pad_r, pad_nxt;

  // The pins come from the board, so two flops guard against metastability.
  // The third stage only registers the value so that the output leaves a flop.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      sync1_r <= 3'h0;
      sync2_r <= 3'h0;
      pin_in_val_r <= 3'h0;
    end else begin
      sync1_r <= status_lamp_pins_i;
      sync2_r <= sync1_r;
      pin_in_val_r <= sync2_r;
    end
  end
  assign pin_in_val = pin_in_val_r;

  // A blink is one off interval followed by a minimum on interval.
  // Activity seen during either interval is remembered and starts the next blink.
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    act_pend_nxt = act_pend_r | phy.activity;
    unique case (state_r)
      GSL_IDLE: begin
        if (phy.link_ok && act_pend_nxt) begin
          state_nxt = GSL_OFF;
          cnt_nxt = BLINK_CYC - 20'h1;
          act_pend_nxt = 1'b0;
        end else begin
          act_pend_nxt = 1'b0;
        end
      end
      GSL_OFF: begin
        cnt_nxt = cnt_r - 20'h1;
        if (cnt_r == 20'h0) begin
          state_nxt = GSL_ON;
          cnt_nxt = BLINK_CYC - 20'h1;
        end
      end
      GSL_ON: begin
        cnt_nxt = cnt_r - 20'h1;
        if (cnt_r == 20'h0) begin
          state_nxt = GSL_IDLE;
        end
      end
      default: begin
        state_nxt = GSL_IDLE;
      end
    endcase
    // Losing the link aborts any blink and drops activity seen without a link.
    if (!phy.link_ok) begin
      state_nxt = GSL_IDLE;
      act_pend_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state_r <= GSL_IDLE;
      cnt_r <= 20'h0;
      act_pend_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      act_pend_r <= act_pend_nxt;
    end
  end

  // Speed lamp lit unless link is up at 10 Mb/s.
  assign speed_lamp_n = phy.cable_on && !phy.aneg_busy && !phy.speed_100;
  assign link_activity_lamp_n = !(phy.link_ok && state_nxt != GSL_OFF);
  assign duplex_lamp_n = !phy.full_duplex;
  assign lamp_n = {duplex_lamp_n, link_activity_lamp_n, speed_lamp_n};

  // The output value is 1 only in push-pull mode; open-drain and lamp modes only sink or release.
  always_comb begin
    pad_nxt.o = 3'h0;
    pad_nxt.oe = 3'h0;
    for (int i = 0; i < `GSL_NPINS; i++) begin
      unique case (pin_mode[2*i +: 2])
        `GSL_MODE_PP: begin
          pad_nxt.o[i] = pin_out_val[i];
          pad_nxt.oe[i] = 1'b1;
        end
        `GSL_MODE_OD: begin
          pad_nxt.oe[i] = !pin_out_val[i];
        end
        `GSL_MODE_LAMP: begin
          pad_nxt.oe[i] = !lamp_n[i];
        end
        default: begin
          pad_nxt.oe[i] = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      pad_r <= '0;
    end else begin
      pad_r <= pad_nxt;
    end
  end
  assign status_lamp_pins = pad_r;

  // Pad values are registered, so each pad check looks one edge after the inputs that caused it; the pin input check looks three edges after.
  a_lamp_never_high: assert property (@(posedge clk_sys) disable iff (!rstn)
    (pin_mode[1:0] == `GSL_MODE_LAMP) |=> !(pad_r.oe[0] && pad_r.o[0]))
    else $error("lamp pin driven high");

  a_lamp1_never_high: assert property (@(posedge clk_sys) disable iff (!rstn)
    (pin_mode[3:2] == `GSL_MODE_LAMP) |=> !pad_r.o[1])
    else $error("link lamp pin driven high");

  a_lamp2_never_high: assert property (@(posedge clk_sys) disable iff (!rstn)
    (pin_mode[5:4] == `GSL_MODE_LAMP) |=> !pad_r.o[2])
    else $error("duplex lamp pin driven high");

  a_speed_10m_off: assert property (@(posedge clk_sys) disable iff (!rstn)
    (pin_mode[1:0] == `GSL_MODE_LAMP && phy.cable_on && !phy.aneg_busy && !phy.speed_100)
    |=> !pad_r.oe[0])
    else $error("speed lamp lit at 10 Mb/s");

  a_speed_100m_on: assert property (@(posedge clk_sys) disable iff (!rstn)
    (pin_mode[1:0] == `GSL_MODE_LAMP && (phy.speed_100 || phy.aneg_busy || !phy.cable_on))
    |=> pad_r.oe[0])
    else $error("speed lamp not lit");

  a_duplex_lamp: assert property (@(posedge clk_sys) disable iff (!rstn)
    (pin_mode[5:4] == `GSL_MODE_LAMP) |=> (pad_r.oe[2] == $past(phy.full_duplex)))
    else $error("duplex lamp wrong");

  a_link_solid: assert property (@(posedge clk_sys) disable iff (!rstn)
    (pin_mode[3:2] == `GSL_MODE_LAMP && phy.link_ok && state_r == GSL_IDLE && !phy.activity && !act_pend_r)
    |=> pad_r.oe[1] && !pad_r.o[1])
    else $error("link lamp not lit");

  a_link_lost_dark: assert property (@(posedge clk_sys) disable iff (!rstn)
    (pin_mode[3:2] == `GSL_MODE_LAMP && !phy.link_ok) |=> !pad_r.oe[1])
    else $error("link lamp lit without link");

  a_link_lost_idle: assert property (@(posedge clk_sys) disable iff (!rstn)
    (!phy.link_ok) |=> state_r == GSL_IDLE && !act_pend_r)
    else $error("blink kept without link");

  a_idle_stays: assert property (@(posedge clk_sys) disable iff (!rstn)
    (state_r == GSL_IDLE && !phy.activity && !act_pend_r) |=> state_r == GSL_IDLE)
    else $error("blink started without activity");

  a_off_start: assert property (@(posedge clk_sys) disable iff (!rstn)
    (state_r == GSL_IDLE && phy.link_ok && phy.activity) |=> state_r == GSL_OFF && cnt_r == BLINK_CYC - 20'h1)
    else $error("blink did not start");

  a_off_count_down: assert property (@(posedge clk_sys) disable iff (!rstn)
    (state_r == GSL_OFF && cnt_r != 20'h0 && phy.link_ok) |=> state_r == GSL_OFF && cnt_r == $past(cnt_r) - 20'h1)
    else $error("off interval cut short");

  a_blink_dark: assert property (@(posedge clk_sys) disable iff (!rstn)
    ($past(pin_mode[3:2]) == `GSL_MODE_LAMP && state_r == GSL_OFF) |-> !pad_r.oe[1])
    else $error("link lamp lit during blink");

  a_off_to_on: assert property (@(posedge clk_sys) disable iff (!rstn)
    (state_r == GSL_OFF && cnt_r == 20'h0 && phy.link_ok) |=> state_r == GSL_ON && cnt_r == BLINK_CYC - 20'h1)
    else $error("minimum on interval skipped");

  a_state_legal: assert property (@(posedge clk_sys) disable iff (!rstn)
    $onehot(state_r))
    else $error("blink state illegal");

  a_act_latched: assert property (@(posedge clk_sys) disable iff (!rstn)
    (state_r != GSL_IDLE && phy.activity && phy.link_ok) |=> act_pend_r)
    else $error("activity lost");

  a_pend_consumed: assert property (@(posedge clk_sys) disable iff (!rstn)
    (state_r == GSL_IDLE && phy.link_ok && (act_pend_r || phy.activity)) |=> state_r == GSL_OFF && !act_pend_r)
    else $error("pending activity not consumed");

  a_pp_output: assert property (@(posedge clk_sys) disable iff (!rstn)
    (pin_mode[1:0] == `GSL_MODE_PP) |=> pad_r.oe[0] && pad_r.o[0] == $past(pin_out_val[0]))
    else $error("push-pull output wrong");

  a_pp_pin2: assert property (@(posedge clk_sys) disable iff (!rstn)
    (pin_mode[5:4] == `GSL_MODE_PP) |=> pad_r.oe[2] && pad_r.o[2] == $past(pin_out_val[2]))
    else $error("push-pull output wrong on pin 2");

  a_od_pin0: assert property (@(posedge clk_sys) disable iff (!rstn)
    (pin_mode[1:0] == `GSL_MODE_OD) |=> !pad_r.o[0] && pad_r.oe[0] == !$past(pin_out_val[0]))
    else $error("open-drain output wrong on pin 0");

  a_od_pin1: assert property (@(posedge clk_sys) disable iff (!rstn)
    (pin_mode[3:2] == `GSL_MODE_OD) |=> !pad_r.o[1] && pad_r.oe[1] == !$past(pin_out_val[1]))
    else $error("open-drain output wrong on pin 1");

  a_input_pin1: assert property (@(posedge clk_sys) disable iff (!rstn)
    (pin_mode[3:2] == `GSL_MODE_IN) |=> !pad_r.oe[1])
    else $error("input pin 1 driven");

  a_input_pin2: assert property (@(posedge clk_sys) disable iff (!rstn)
    (pin_mode[5:4] == `GSL_MODE_IN) |=> !pad_r.oe[2])
    else $error("input pin 2 driven");

  a_pin_sync_delay: assert property (@(posedge clk_sys) disable iff (!rstn)
    (rstn && $past(rstn, 3)) |-> pin_in_val_r == $past(status_lamp_pins_i, 3))
    else $error("pin input latency wrong");
endmodule : gsl_status_lamps

//--- gsl_regs.svh
// Constants for the status lamp and general-purpose pin block.
// Summary of operation
// - Pins in lamp mode are only pulled low, never driven high.
// - Speed lamp lit at 100 Mb/s, during auto-negotiation, and with cable unplugged.
// - Speed lamp released high only while link runs at 10 Mb/s.
// - Link lamp lit steadily while link valid and no blink in progress.
// - Activity turns the link lamp off for 80 ms.
// - After an off pulse, lamp lit at least 80 ms before another blink.
// - Duplex lamp lit in full duplex, released otherwise.
`ifndef GSL_REGS_SVH
`define GSL_REGS_SVH
`define GSL_CLK_HZ 10000000
`define GSL_BLINK_MS 80
`define GSL_BLINK_CYC ((`GSL_CLK_HZ / 1000) * `GSL_BLINK_MS)
`define GSL_CNT_W 20
`define GSL_NPINS 3
`define GSL_MODE_IN 2'h0
`define GSL_MODE_PP 2'h1
`define GSL_MODE_OD 2'h2
`define GSL_MODE_LAMP 2'h3
`endif

//--- gsl_pkg.sv
// Types for the status lamp and general-purpose pin block.
package gsl_pkg;
  typedef enum logic [2:0] {
    GSL_IDLE = 3'h1,
    GSL_OFF = 3'h2,
    GSL_ON = 3'h4
  } gsl_blink_e;
  typedef struct packed {
    logic speed_100;
    logic full_duplex;
    logic aneg_busy;
    logic cable_on;
    logic link_ok;
    logic activity;
  } gsl_phy_s;
  typedef struct packed {
    logic [2:0] o;
    logic [2:0] oe;
  } gsl_pad_s;
endpackage : gsl_pkg

//--- gsl_board.sv
// Board model: pull-ups on the three pins plus an optional outside driver.
`timescale 1ns/100ps
module gsl_board (
  input wire gsl_pkg::gsl_pad_s pad,
  input wire logic [2:0] ext_oe,
  input wire logic [2:0] ext_val,
  output logic [2:0] lvl
);
  import gsl_pkg::*;
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      lvl[i] = pad.oe[i] ? pad.o[i] : (ext_oe[i] ? ext_val[i] : 1'b1);
    end
  end
endmodule : gsl_board

//--- tb.sv
// Self-checking testbench for the status lamp and pin block.
`timescale 1ns/100ps
module tb;
  import gsl_pkg::*;
  logic clk_sys = 0;
  logic rstn = 0;
  gsl_phy_s phy = '0;
  logic [5:0] pin_mode = 6'h3f;
  logic [2:0] pin_out_val = 3'h0;
  logic [2:0] ext_oe = 3'h0;
  logic [2:0] ext_val = 3'h0;
  logic [2:0] lvl;
  logic [2:0] pin_in_val;
  gsl_pad_s pad;
  int fails = 0;
  int samples_checked = 0;
  gsl_status_lamps dut (.clk_sys(clk_sys), .rstn(rstn), .phy(phy), .pin_mode(pin_mode),
    .pin_out_val(pin_out_val), .status_lamp_pins_i(lvl), .status_lamp_pins(pad), .pin_in_val(pin_in_val));
  gsl_board board (.pad(pad), .ext_oe(ext_oe), .ext_val(ext_val), .lvl(lvl));
  initial forever #50 clk_sys = ~clk_sys;
  task step(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : step
  task cmp(input logic a, input logic e);
    samples_checked++;
    if (a !== e) begin
      fails++;
      $display("Error at %0t: got %b expected %b", $time, a, e);
    end
  endtask : cmp
  task end_sim;
    if (fails == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_sim
  task t_speed;
    for (int k = 0; k < 8; k++) begin
      {phy.cable_on, phy.aneg_busy, phy.speed_100} = 3'(k);
      step(2);
      cmp(lvl[0], k == 4);
      cmp(|(pad.o & pad.oe), 1'b0);
    end
    $display("speed test done");
  endtask : t_speed
  task t_duplex;
    for (int k = 0; k < 2; k++) begin
      phy.full_duplex = k[0];
      step(2);
      cmp(lvl[2], !k[0]);
    end
    $display("duplex test done");
  endtask : t_duplex
  task t_link;
    phy.link_ok = 1;
    step(2);
    cmp(lvl[1], 1'b0);
    phy.activity = 1;
    step(1);
    phy.activity = 0;
    step(2);
    cmp(lvl[1], 1'b1);
    phy.activity = 1;
    step(1);
    phy.activity = 0;
    step(2000);
    cmp(lvl[1], 1'b1);
    phy.link_ok = 0;
    step(2);
    cmp(lvl[1], 1'b1);
    phy.link_ok = 1;
    step(2);
    cmp(lvl[1], 1'b0);
    $display("link test done");
  endtask : t_link
  task t_gpio;
    pin_mode = 6'h09;
    pin_out_val = 3'h2;
    ext_oe = 3'h4;
    step(4);
    cmp(lvl[0], 1'b0);
    cmp(lvl[1], 1'b1);
    cmp(pin_in_val[2], 1'b0);
    pin_out_val = 3'h1;
    ext_val = 3'h4;
    step(4);
    cmp(pad.oe[0] & lvl[0], 1'b1);
    cmp(lvl[1], 1'b0);
    cmp(pin_in_val[2], 1'b1);
    cmp(pin_in_val[0], 1'b1);
    cmp(pin_in_val[1], 1'b0);
    pin_mode = 6'h12;
    pin_out_val = 3'h0;
    ext_oe = 3'h2;
    ext_val = 3'h2;
    step(4);
    cmp(lvl[0], 1'b0);
    cmp(pad.oe[0], 1'b1);
    cmp(pin_in_val[1], 1'b1);
    cmp(lvl[2], 1'b0);
    cmp(pad.oe[2], 1'b1);
    ext_oe = 3'h0;
    pin_mode = 6'h3f;
    $display("gpio test done");
  endtask : t_gpio
  initial begin
    repeat (6) @(posedge clk_sys);
    #1 rstn = 1;
    t_speed();
    t_duplex();
    t_link();
    t_gpio();
    $display("fails %0d samples_checked %0d", fails, samples_checked);
    end_sim();
  end
  initial begin
    #1000000;
    fails++;
    end_sim();
  end
endmodule : tb
